// [design/irq_ctrl_pkg.sv]
// Package for the two-level interrupt controller: constants and carriers
package irq_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h00_0008;
  localparam logic [PC_W-1:0] VEC_LOW = 21'h00_0018;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_INT_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_ENABLES = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_PRIORITY = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PERIPH = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h6;
  // Field positions
  localparam int BIT_PRIO_MODE = 7;
  localparam int BIT_GLOBAL_HIGH = 7;
  localparam int BIT_GLOBAL_LOW = 6;
  // Reset values
  localparam logic [DATA_W-1:0] RST_INT_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_RESET_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_PRIORITY = 8'hFF;
  localparam logic [DATA_W-1:0] RST_PERIPH = 8'hF8;
  // Entry latency: event sampling takes two, decision plus vector
  localparam int LAT_MIN_CYC = 3;
  localparam int LAT_MAX_CYC = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic vec_load;
    logic push;
    logic [PC_W-1:0] vector;
  } core_cmd_t;

  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW = 2'b01,
    LVL_HIGH = 2'b10
  } level_t;
endpackage : irq_ctrl_pkg

// [design/irq_ctrl.sv]
// Two-level priority interrupt controller, core side
module irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire reg_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [N_SRC-1:0] src_event,
  input wire logic return_from_interrupt_instr,
  output core_cmd_t core_cmd,
  output logic in_service
);

  // Registers
  logic [DATA_W-1:0] reset_ctrl_q;
  logic [DATA_W-1:0] int_ctrl_q;
  logic [N_SRC-1:0] flag_q;
  logic [N_SRC-1:0] en_q;
  logic [N_SRC-1:0] prio_q;
  logic [N_SRC-1:0] periph_q;
  logic [N_SRC-1:0] ev_s1_q;
  logic [N_SRC-1:0] ev_s2_q;
  logic [N_SRC-1:0] ev_old_q;
  logic high_active_q;
  logic low_active_q;
  logic in_service_q;
  logic [DATA_W-1:0] rdata_q;
  core_cmd_t cmd_q;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = a == ofs;
  endfunction : hit

  wire wr_rst_ctrl = reg_req.wr && hit(reg_req.addr, OFS_RESET_CTRL);
  wire wr_int_ctrl = reg_req.wr && hit(reg_req.addr, OFS_INT_CTRL);
  wire wr_flags = reg_req.wr && hit(reg_req.addr, OFS_FLAGS);
  wire wr_en = reg_req.wr && hit(reg_req.addr, OFS_ENABLES);
  wire wr_prio = reg_req.wr && hit(reg_req.addr, OFS_PRIORITY);
  wire wr_periph = reg_req.wr && hit(reg_req.addr, OFS_PERIPH);

  wire prio_mode = reset_ctrl_q[BIT_PRIO_MODE];
  wire global_high_enable = int_ctrl_q[BIT_GLOBAL_HIGH];
  wire global_low_enable = int_ctrl_q[BIT_GLOBAL_LOW];

  // Edge of the synchronised event marks one occurrence
  wire [N_SRC-1:0] ev_pulse = ev_s2_q & ~ev_old_q;

  // Flag and enable pairing per source
  logic [N_SRC-1:0] armed;
  logic [N_SRC-1:0] hi_req_v;
  logic [N_SRC-1:0] lo_req_v;
  logic [N_SRC-1:0] cm_req_v;
  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi++) begin : g_src
      assign armed[gi] = flag_q[gi] & en_q[gi];
      assign hi_req_v[gi] = armed[gi] & prio_q[gi];
      // Every low source obeys bit 6, peripheral or not
      assign lo_req_v[gi] = armed[gi] & ~prio_q[gi];
      // Peripheral sources need the bit-6 enable in compatibility mode
      assign cm_req_v[gi] = armed[gi]
                            & (~periph_q[gi] | global_low_enable);
    end
  endgenerate

  // Mode and level gating
  wire high_req = prio_mode && global_high_enable && |hi_req_v;
  wire low_req = prio_mode && global_low_enable && |lo_req_v
                 && !high_active_q;
  wire compat_req = !prio_mode && global_high_enable
                    && |cm_req_v;
  // A command cycle blocks a second entry before the gate clears
  wire busy = cmd_q.vec_load;
  wire take_high = !busy && (high_req || compat_req);
  wire take_low = !busy && !take_high && low_req && !low_active_q;
  wire take_any = take_high || take_low;
  wire [PC_W-1:0] vec_sel = take_high ? VEC_HIGH : VEC_LOW;

  // Read mux
  logic [DATA_W-1:0] rd_mux;
  assign rd_mux =
    hit(reg_req.addr, OFS_RESET_CTRL) ? reset_ctrl_q :
    hit(reg_req.addr, OFS_INT_CTRL) ? int_ctrl_q :
    hit(reg_req.addr, OFS_FLAGS) ? DATA_W'(flag_q) :
    hit(reg_req.addr, OFS_ENABLES) ? DATA_W'(en_q) :
    hit(reg_req.addr, OFS_PRIORITY) ? DATA_W'(prio_q) :
    hit(reg_req.addr, OFS_PERIPH) ? DATA_W'(periph_q) :
    hit(reg_req.addr, OFS_STATUS) ?
      {6'h00, high_active_q, low_active_q} : 8'h00;

  // Return handling: which level ends, which enable comes back
  wire ret_high = return_from_interrupt_instr && high_active_q;
  wire ret_low = return_from_interrupt_instr && !high_active_q
                 && low_active_q;
  wire ret_compat = return_from_interrupt_instr && !prio_mode;
  // Next service levels; the status output is registered from them
  wire high_active_d = take_high
                       || (high_active_q && !ret_high && !ret_compat);
  wire low_active_d = take_low || (low_active_q && !ret_low);

  logic [DATA_W-1:0] int_ctrl_d;
  always_comb begin
    int_ctrl_d = wr_int_ctrl ? reg_req.wdata : int_ctrl_q;
    if (return_from_interrupt_instr) begin
      // Compatibility re-enables bit 7 only
      if (!prio_mode || ret_high || !low_active_q) begin
        int_ctrl_d[BIT_GLOBAL_HIGH] = 1'b1;
      end else begin
        int_ctrl_d[BIT_GLOBAL_LOW] = 1'b1;
      end
    end
    if (take_high) begin
      int_ctrl_d[BIT_GLOBAL_HIGH] = 1'b0;
    end else if (take_low) begin
      int_ctrl_d[BIT_GLOBAL_LOW] = 1'b0;
    end
  end

  // Event wins over a software clear
  wire [N_SRC-1:0] flag_d =
    (wr_flags ? reg_req.wdata[N_SRC-1:0] : flag_q) | ev_pulse;

  always_ff @(posedge core_clk) begin
    ev_s1_q <= src_event;
    ev_s2_q <= ev_s1_q;
    ev_old_q <= ev_s2_q;
    if (rst) begin
      reset_ctrl_q <= RST_RESET_CTRL;
      int_ctrl_q <= RST_INT_CTRL;
      flag_q <= '0;
      en_q <= '0;
      prio_q <= N_SRC'(RST_PRIORITY);
      periph_q <= N_SRC'(RST_PERIPH);
      ev_old_q <= '0;
      rdata_q <= '0;
    end else begin
      if (wr_rst_ctrl) reset_ctrl_q <= reg_req.wdata;
      int_ctrl_q <= int_ctrl_d;
      flag_q <= flag_d;
      if (wr_en) en_q <= reg_req.wdata[N_SRC-1:0];
      if (wr_prio) prio_q <= reg_req.wdata[N_SRC-1:0];
      if (wr_periph) periph_q <= reg_req.wdata[N_SRC-1:0];
      rdata_q <= reg_req.rd ? rd_mux : 8'h00;
    end
  end

  // Service levels and the push/vector command
  always_ff @(posedge core_clk) begin
    if (rst) begin
      high_active_q <= 1'b0;
      low_active_q <= 1'b0;
      in_service_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      high_active_q <= high_active_d;
      low_active_q <= low_active_d;
      in_service_q <= high_active_d || low_active_d;
      cmd_q.vec_load <= take_any;
      cmd_q.push <= take_any;
      cmd_q.vector <= take_any ? vec_sel : cmd_q.vector;
    end
  end

  assign reg_rdata = rdata_q;
  assign core_cmd = cmd_q;
  assign in_service = in_service_q;

  property p_compat_vector;
    @(posedge core_clk) disable iff (rst)
      cmd_q.vec_load && !$past(prio_mode) |-> cmd_q.vector == VEC_HIGH;
  endproperty
  a_compat_vector: assert property (p_compat_vector)
    else $error("compat mode used a vector other than high");

  property p_low_vec;
    @(posedge core_clk) disable iff (rst)
      take_low |=> cmd_q.vector == VEC_LOW && cmd_q.push;
  endproperty
  a_low_vec: assert property (p_low_vec)
    else $error("low entry did not load low vector");

  property p_no_low_in_high;
    @(posedge core_clk) disable iff (rst)
      high_active_q |=> !(cmd_q.vec_load && cmd_q.vector == VEC_LOW);
  endproperty
  a_no_low_in_high: assert property (p_no_low_in_high)
    else $error("low taken during high service");

  property p_preempt;
    @(posedge core_clk) disable iff (rst)
      low_active_q && high_req && !busy |=> high_active_q && cmd_q.vec_load;
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("high request did not preempt low service");

  property p_clear_global_high;
    @(posedge core_clk) disable iff (rst)
      take_high && !return_from_interrupt_instr |=> !global_high_enable;
  endproperty
  a_clear_global_high: assert property (p_clear_global_high)
    else $error("global enable not cleared on entry");

  property p_high_first;
    @(posedge core_clk) disable iff (rst)
      high_req && low_req && !busy |=> cmd_q.vector == VEC_HIGH;
  endproperty
  a_high_first: assert property (p_high_first)
    else $error("low served before simultaneous high");

  property p_flag_sticky;
    @(posedge core_clk) disable iff (rst)
      ev_pulse[0] |=> flag_q[0] ##1 (flag_q[0] || $past(wr_flags));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("event flag not set or not held");

  property p_latency;
    @(posedge core_clk) disable iff (rst)
      $rose(src_event[0]) && en_q[0] && !flag_q[0] && global_high_enable
      && !prio_mode && !periph_q[0] && !in_service && !busy
      && !reg_req.wr && !return_from_interrupt_instr
      |-> ##[3:4] cmd_q.vec_load;
  endproperty
  a_latency: assert property (p_latency)
    else $error("pin event latency outside three to four cycles");

  property p_return_compat;
    @(posedge core_clk) disable iff (rst)
      return_from_interrupt_instr && !prio_mode && !take_any
      |=> global_high_enable;
  endproperty
  a_return_compat: assert property (p_return_compat)
    else $error("return did not restore global enable");

  property p_cmd_pulse;
    @(posedge core_clk) disable iff (rst)
      cmd_q.vec_load |=> !cmd_q.vec_load;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("vector load held longer than one cycle");

  property p_push_pair;
    @(posedge core_clk) disable iff (rst)
      cmd_q.push == cmd_q.vec_load;
  endproperty
  a_push_pair: assert property (p_push_pair)
    else $error("push and vector load out of step");

  property p_vec_set;
    @(posedge core_clk) disable iff (rst)
      cmd_q.vec_load
      |-> cmd_q.vector == VEC_HIGH || cmd_q.vector == VEC_LOW;
  endproperty
  a_vec_set: assert property (p_vec_set)
    else $error("vector load with an unknown vector address");

  property p_clear_global_low;
    @(posedge core_clk) disable iff (rst)
      take_low && !return_from_interrupt_instr |=> !global_low_enable;
  endproperty
  a_clear_global_low: assert property (p_clear_global_low)
    else $error("low enable not cleared on low entry");

  property p_return_high;
    @(posedge core_clk) disable iff (rst)
      ret_high && prio_mode && !take_any |=> global_high_enable;
  endproperty
  a_return_high: assert property (p_return_high)
    else $error("return from high service did not restore bit 7");

  property p_return_low;
    @(posedge core_clk) disable iff (rst)
      ret_low && prio_mode && !take_any |=> global_low_enable;
  endproperty
  a_return_low: assert property (p_return_low)
    else $error("return from low service did not restore bit 6");

  property p_prio_gate;
    @(posedge core_clk) disable iff (rst)
      prio_mode && !global_high_enable && !global_low_enable
      |=> !cmd_q.vec_load;
  endproperty
  a_prio_gate: assert property (p_prio_gate)
    else $error("entry while both level enables were clear");

  property p_periph_gate;
    @(posedge core_clk) disable iff (rst)
      !prio_mode && !global_low_enable && (armed & ~periph_q) == '0
      |=> !cmd_q.vec_load;
  endproperty
  a_periph_gate: assert property (p_periph_gate)
    else $error("peripheral entry without the peripheral enable");

endmodule : irq_ctrl

// [sim/core_model.sv]
// Behavioural core model: program counter, return stack, return pulse
module core_model
  import irq_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire core_cmd_t core_cmd,
  input wire logic ret_req,
  output logic return_from_interrupt_instr,
  output logic [PC_W-1:0] pc_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PC_W-1:0] stack_q [$];
  assign return_from_interrupt_instr = ret_req;
  always @(posedge core_clk) begin
    if (rst) begin
      pc_q <= 21'h00_0100;
      stack_q.delete();
    end else if (core_cmd.vec_load && core_cmd.push) begin
      stack_q.push_back(pc_q);
      pc_q <= core_cmd.vector;
    end else if (return_from_interrupt_instr && stack_q.size() > 0) begin
      pc_q <= stack_q.pop_back();
    end else begin
      pc_q <= pc_q + 21'h00_0001;
    end
  end
endmodule : core_model

// [sim/two_level_interrupt_controller_tb.sv]
// Self-checking bench for the two-level interrupt controller
module two_level_interrupt_controller_tb
  import irq_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, ret_req, return_from_interrupt_instr, in_svc;
  reg_req_t req;
  logic [DATA_W-1:0] rdata;
  logic [7:0] ev;
  core_cmd_t cmd;
  logic [PC_W-1:0] pc;
  int num_errors = 0;
  int n_compared = 0;

  irq_ctrl irq_ctrl_i (.core_clk(core_clk), .rst(rst), .reg_req(req),
    .reg_rdata(rdata), .src_event(ev),
    .return_from_interrupt_instr(return_from_interrupt_instr),
    .core_cmd(cmd), .in_service(in_svc));
  core_model core_model_i (.core_clk(core_clk), .rst(rst),
    .core_cmd(cmd), .ret_req(ret_req),
    .return_from_interrupt_instr(return_from_interrupt_instr), .pc_q(pc));

  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Single-byte writes only, never a block move
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 chk("reg", 32'(e), 32'(rdata));
  endtask : rd
  task automatic ret();
    @(posedge core_clk);
    ret_req <= 1'b1;
    @(posedge core_clk);
    ret_req <= 1'b0;
  endtask : ret
  // Zero vector means no entry may follow within eight cycles
  task automatic fire(input logic [7:0] m, input logic [PC_W-1:0] v);
    int n;
    n = 0;
    @(posedge core_clk);
    ev <= m;
    while (n < 8 && cmd.vec_load !== 1'b1) begin
      @(posedge core_clk);
      #1 n++;
    end
    ev <= 8'h00;
    if (v == '0) chk("no entry", 32'd8, 32'(n));
    else begin
      chk("vector", 32'(v), 32'(cmd.vector));
      chk("latency", 32'd1,
          32'(n >= LAT_MIN_CYC && n <= LAT_MAX_CYC));
      chk("push", 32'd1, 32'(cmd.push));
      @(posedge core_clk);
      #1 chk("pc", 32'(v), 32'(pc));
      chk("service", 32'd1, 32'(in_svc));
      chk("pulse", 32'd0, 32'(cmd.vec_load));
    end
  endtask : fire

  task automatic t_reset();
    rd(OFS_RESET_CTRL, 8'h00);
    rd(OFS_INT_CTRL, 8'h00);
    rd(OFS_PRIORITY, 8'hFF);
    rd(OFS_PERIPH, 8'hF8);
    rd(OFS_FLAGS, 8'h00);
    rd(4'h7, 8'h00);
  endtask : t_reset
  task automatic t_poll();
    fire(8'h01, '0);
    rd(OFS_FLAGS, 8'h01);
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 8'h00);
  endtask : t_poll
  task automatic t_compat();
    wr(OFS_ENABLES, 8'h0F);
    wr(OFS_PRIORITY, 8'hF0);
    wr(OFS_INT_CTRL, 8'h80);
    fire(8'h08, '0);
    wr(OFS_FLAGS, 8'h00);
    fire(8'h01, VEC_HIGH);
    rd(OFS_INT_CTRL, 8'h00);
    rd(OFS_FLAGS, 8'h01);
    wr(OFS_FLAGS, 8'h00);
    ret();
    rd(OFS_INT_CTRL, 8'h80);
    chk("service", 32'd0, 32'(in_svc));
    wr(OFS_INT_CTRL, 8'h00);
  endtask : t_compat
  task automatic t_prio();
    wr(OFS_RESET_CTRL, 8'h80);
    wr(OFS_PRIORITY, 8'h04);
    wr(OFS_INT_CTRL, 8'hC0);
    fire(8'h02, VEC_LOW);
    rd(OFS_INT_CTRL, 8'h80);
    rd(OFS_STATUS, 8'h01);
    fire(8'h04, VEC_HIGH);
    rd(OFS_INT_CTRL, 8'h00);
    rd(OFS_STATUS, 8'h03);
    wr(OFS_INT_CTRL, 8'h40);
    fire(8'h02, '0);
    wr(OFS_FLAGS, 8'h00);
    ret();
    rd(OFS_INT_CTRL, 8'hC0);
    wr(OFS_INT_CTRL, 8'h80);
    ret();
    rd(OFS_INT_CTRL, 8'hC0);
    wr(OFS_INT_CTRL, 8'h80);
    fire(8'h08, '0);
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_INT_CTRL, 8'hC0);
    fire(8'h06, VEC_HIGH);
  endtask : t_prio

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #100us;
    num_errors++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    ev = 8'h00;
    ret_req = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_poll();
    t_compat();
    t_prio();
    conclude();
  end
endmodule : two_level_interrupt_controller_tb
